// *** rtl/tmr_cap_pkg.sv ***
package tmr_cap_pkg;
  // Register word offsets (byte addresses)
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_PRM = 6'h04;
  localparam logic [5:0] OFF_COUNT = 6'h08;
  localparam logic [5:0] OFF_CAPCMP_A = 6'h0C;
  localparam logic [5:0] OFF_CAPCMP_B = 6'h10;
  localparam logic [5:0] OFF_IRQ_STS = 6'h14;
  localparam logic [5:0] OFF_IRQ_CLR = 6'h18;
  localparam logic [5:0] OFF_IRQ_EN = 6'h1C;
  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_OS_EN = 3;
  localparam int CTRL_OS_SWTRIG = 4;
  localparam int CTRL_EXT_CNT = 5;
  localparam int CTRL_A_CMP = 6;
  localparam int CTRL_B_CMP = 7;
  localparam int CTRL_W = 8;
  // Prescaler mode register fields
  localparam int PRM_SEL_LO = 0;
  localparam int PRM_EDGE_A_LO = 2;
  localparam int PRM_EDGE_B_LO = 4;
  localparam int PRM_W = 6;
  localparam logic [PRM_W-1:0] PRM_RESET = 6'h00;
  // Status bits
  localparam int STS_A = 0;
  localparam int STS_B = 1;
  localparam int STS_OVF = 2;
  localparam int STS_W = 3;
  // Counter modes
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_CMP_CLR = 2'h1;
  localparam logic [1:0] MODE_EDGE_CLR = 2'h2;
  // Valid-edge selections
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Counter limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage

// *** rtl/edge_filter.sv ***
`timescale 1ns/10ps
module edge_filter (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Sampling and control
  input wire logic sample_in,
  input wire logic run_in,
  input wire logic [1:0] edge_sel_in,
  // Pin and result
  input wire logic pin_in,
  output logic edge_out
);
  logic samp_r;
  logic stable_r;
  logic ran_r;
  logic stable_nxt;
  logic hit;

  // Level accepted only when two consecutive samples agree
  always_comb begin
    stable_nxt = stable_r;
    if (sample_in && (pin_in == samp_r)) begin
      stable_nxt = pin_in;
    end
  end

  // Edge of the accepted level matched against the valid-edge setting
  always_comb begin
    hit = 1'b0;
    if (stable_nxt != stable_r) begin
      unique case (edge_sel_in)
        tmr_cap_pkg::EDGE_FALL: hit = ~stable_nxt;
        tmr_cap_pkg::EDGE_RISE: hit = stable_nxt;
        tmr_cap_pkg::EDGE_BOTH: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Remembers that the counter has run since reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ran_r <= 1'b0;
    end else if (run_in) begin
      ran_r <= 1'b1;
    end
  end

  // Sample register; level stays low from reset until first run
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      samp_r <= 1'b0;
      stable_r <= 1'b0;
    end else if (run_in) begin
      if (sample_in) begin
        samp_r <= pin_in;
      end
      stable_r <= stable_nxt;
    end else if (ran_r) begin
      samp_r <= pin_in;
      stable_r <= pin_in;
    end
  end

  // Edge pulse, suppressed while stopped
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      edge_out <= 1'b0;
    end else begin
      edge_out <= run_in & hit;
    end
  end

  a_two_samples: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in)
    (run_in && sample_in && pin_in != samp_r) |=> $stable(stable_r))
    else $error("level accepted after a single sample");
  a_first_rise: assert property (@(posedge clk_sys_in)
    disable iff (!rst_b_in) (!ran_r && !run_in) |=> !stable_r)
    else $error("level left low state before first run");
endmodule

// *** rtl/timer_capture_edge_input.sv ***
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - One-shot works in free-running and edge-clear modes, never compare-clear.
// - Input-a edge used as count clock disables captures into register b.
// - Counter value is captured on the count clock falling edge.
// - Capture interrupt rises at the following count clock rising edge.
// - A register in compare mode ignores capture triggers.
// - High pin at first enable after reset gives a rising edge once two samples agree.
// - High pin at re-enable after a stop gives no rising edge.
// - Input-a filter samples system clock for counting, count clock otherwise.
// - Capture starts only after two consecutive samples of valid level.
// - Input pins are ignored while the timer is stopped.
// - Capture wins over a coinciding register write; written value lost.
module timer_capture_edge_input #(
  parameter int DIV_BASE = 1
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Timer pins
  input wire logic timer_input_a_in,
  input wire logic timer_input_b_in,
  output logic oneshot_out,
  // Interrupts
  output logic irq_capcmp_a_out,
  output logic irq_capcmp_b_out,
  output logic irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic ack_r;
  logic wr_go;
  logic [tmr_cap_pkg::CTRL_W-1:0] ctrl_r;
  logic [tmr_cap_pkg::PRM_W-1:0] prescaler_mode_reg_r;
  logic [15:0] up_counter_16_r;
  logic [15:0] capcmp_reg_a_r;
  logic [15:0] capcmp_reg_b_r;
  logic [tmr_cap_pkg::STS_W-1:0] sts_r;
  logic [tmr_cap_pkg::STS_W-1:0] irq_en_r;
  logic [tmr_cap_pkg::STS_W-1:0] sts_ev;
  logic [tmr_cap_pkg::STS_W-1:0] sts_clr;
  logic run;
  logic ext_cnt;
  logic a_cmp;
  logic b_cmp;
  logic [1:0] mode;
  logic [7:0] presc_r;
  logic [7:0] half;
  logic cnt_clk_r;
  logic toggle;
  logic rise_tick;
  logic fall_tick;
  logic samp_a;
  logic edge_a;
  logic edge_b;
  logic cnt_inc;
  logic cnt_clr;
  logic ovf;
  logic trig_a_r;
  logic trig_b_r;
  logic cap_a_do;
  logic cap_b_do;
  logic pend_a_r;
  logic pend_b_r;
  logic match_a;
  logic match_b;
  logic os_trig;
  logic os_act_r;

  assign run = ctrl_r[tmr_cap_pkg::CTRL_RUN];
  assign ext_cnt = ctrl_r[tmr_cap_pkg::CTRL_EXT_CNT];
  assign a_cmp = ctrl_r[tmr_cap_pkg::CTRL_A_CMP];
  assign b_cmp = ctrl_r[tmr_cap_pkg::CTRL_B_CMP];
  assign mode = ctrl_r[tmr_cap_pkg::CTRL_MODE_LO +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request completes
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
  assign wr_go = avs_write_in & ack_r;
  assign sts_clr = (wr_go && avs_address_in == tmr_cap_pkg::OFF_IRQ_CLR) ?
    avs_writedata_in[tmr_cap_pkg::STS_W-1:0] : '0;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
    end
  end

  // Read data captured in the wait cycle; a capture in flight may race it
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      unique case (avs_address_in)
        tmr_cap_pkg::OFF_CTRL: avs_readdata_out <= 32'(ctrl_r);
        tmr_cap_pkg::OFF_PRM: avs_readdata_out <= 32'(prescaler_mode_reg_r);
        tmr_cap_pkg::OFF_COUNT: avs_readdata_out <= 32'(up_counter_16_r);
        tmr_cap_pkg::OFF_CAPCMP_A: avs_readdata_out <= 32'(capcmp_reg_a_r);
        tmr_cap_pkg::OFF_CAPCMP_B: avs_readdata_out <= 32'(capcmp_reg_b_r);
        tmr_cap_pkg::OFF_IRQ_STS: avs_readdata_out <= 32'(sts_r);
        tmr_cap_pkg::OFF_IRQ_EN: avs_readdata_out <= 32'(irq_en_r);
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Control register; software trigger bit is a self-clearing strobe
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r <= '0;
    end else if (wr_go && avs_address_in == tmr_cap_pkg::OFF_CTRL) begin
      ctrl_r <= avs_writedata_in[tmr_cap_pkg::CTRL_W-1:0];
    end else begin
      ctrl_r[tmr_cap_pkg::CTRL_OS_SWTRIG] <= 1'b0;
    end
  end

  // Prescaler and edge selection only accepted while stopped
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prescaler_mode_reg_r <= tmr_cap_pkg::PRM_RESET;
    end else if (wr_go && !run &&
                 avs_address_in == tmr_cap_pkg::OFF_PRM) begin
      prescaler_mode_reg_r <= avs_writedata_in[tmr_cap_pkg::PRM_W-1:0];
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_en_r <= '0;
    end else if (wr_go && avs_address_in == tmr_cap_pkg::OFF_IRQ_EN) begin
      irq_en_r <= avs_writedata_in[tmr_cap_pkg::STS_W-1:0];
    end
  end

  // Sticky status, a new event wins over a clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sts_r <= '0;
      irq_out <= 1'b0;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_ev;
      irq_out <= |(((sts_r & ~sts_clr) | sts_ev) & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler makes the count clock as a square wave
  assign half = 8'(DIV_BASE) <<
    prescaler_mode_reg_r[tmr_cap_pkg::PRM_SEL_LO +: 2];
  assign toggle = run && (presc_r == half - 8'h01);
  assign rise_tick = toggle & ~cnt_clk_r;
  assign fall_tick = toggle & cnt_clk_r;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      presc_r <= 8'h00;
      cnt_clk_r <= 1'b0;
    end else if (!run) begin
      presc_r <= 8'h00;
      cnt_clk_r <= 1'b0;
    end else if (toggle) begin
      presc_r <= 8'h00;
      cnt_clk_r <= ~cnt_clk_r;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input a filter runs on the system clock when it is the count source
  assign samp_a = ext_cnt ? 1'b1 : rise_tick;

  edge_filter u_filt_a (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .sample_in(samp_a),
    .run_in(run),
    .edge_sel_in(prescaler_mode_reg_r[tmr_cap_pkg::PRM_EDGE_A_LO +: 2]),
    .pin_in(timer_input_a_in),
    .edge_out(edge_a)
  );

  edge_filter u_filt_b (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .sample_in(rise_tick),
    .run_in(run),
    .edge_sel_in(prescaler_mode_reg_r[tmr_cap_pkg::PRM_EDGE_B_LO +: 2]),
    .pin_in(timer_input_b_in),
    .edge_out(edge_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter: count, clear on match or on input a edge
  assign cnt_inc = ext_cnt ? edge_a : rise_tick;
  assign match_a = rise_tick && up_counter_16_r == capcmp_reg_a_r;
  assign match_b = rise_tick && up_counter_16_r == capcmp_reg_b_r;
  assign cnt_clr = (mode == tmr_cap_pkg::MODE_CMP_CLR && match_a) ||
    (mode == tmr_cap_pkg::MODE_EDGE_CLR && edge_a && !ext_cnt);
  assign ovf = cnt_inc && !cnt_clr && up_counter_16_r == tmr_cap_pkg::CNT_MAX;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      up_counter_16_r <= tmr_cap_pkg::CNT_ZERO;
    end else if (!run || cnt_clr) begin
      up_counter_16_r <= tmr_cap_pkg::CNT_ZERO;
    end else if (cnt_inc) begin
      up_counter_16_r <= up_counter_16_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger waits for the next count clock falling edge
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      trig_a_r <= 1'b0;
      trig_b_r <= 1'b0;
    end else if (!run) begin
      trig_a_r <= 1'b0;
      trig_b_r <= 1'b0;
    end else begin
      trig_a_r <= (trig_a_r & ~fall_tick) | (edge_b & ~a_cmp);
      trig_b_r <= (trig_b_r & ~fall_tick) |
        (edge_a & ~b_cmp & ~ext_cnt);
    end
  end

  assign cap_a_do = trig_a_r & fall_tick;
  assign cap_b_do = trig_b_r & fall_tick;

  // Capture registers; capture has priority over a bus write
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capcmp_reg_a_r <= tmr_cap_pkg::CNT_ZERO;
    end else if (cap_a_do) begin
      capcmp_reg_a_r <= up_counter_16_r;
    end else if (wr_go && avs_address_in == tmr_cap_pkg::OFF_CAPCMP_A) begin
      capcmp_reg_a_r <= avs_writedata_in[15:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capcmp_reg_b_r <= tmr_cap_pkg::CNT_ZERO;
    end else if (cap_b_do) begin
      capcmp_reg_b_r <= up_counter_16_r;
    end else if (wr_go && avs_address_in == tmr_cap_pkg::OFF_CAPCMP_B) begin
      capcmp_reg_b_r <= avs_writedata_in[15:0];
    end
  end

  // Capture interrupt held until the next count clock rising edge
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_a_r <= 1'b0;
      pend_b_r <= 1'b0;
      irq_capcmp_a_out <= 1'b0;
      irq_capcmp_b_out <= 1'b0;
    end else begin
      pend_a_r <= run & (cap_a_do | (pend_a_r & ~rise_tick));
      pend_b_r <= run & (cap_b_do | (pend_b_r & ~rise_tick));
      irq_capcmp_a_out <= (pend_a_r & rise_tick) | (match_a & a_cmp);
      irq_capcmp_b_out <= (pend_b_r & rise_tick) | (match_b & b_cmp);
    end
  end

  assign sts_ev = {ovf, irq_capcmp_b_out, irq_capcmp_a_out};

  ////////////////////////////////////////////////////////////////////////////
  // One-shot: armed by a trigger, high from match b to match a
  assign os_trig = run && ctrl_r[tmr_cap_pkg::CTRL_OS_EN] &&
    mode != tmr_cap_pkg::MODE_CMP_CLR &&
    (ctrl_r[tmr_cap_pkg::CTRL_OS_SWTRIG] ||
     (mode == tmr_cap_pkg::MODE_EDGE_CLR && edge_a));

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      os_act_r <= 1'b0;
      oneshot_out <= 1'b0;
    end else if (!run || mode == tmr_cap_pkg::MODE_CMP_CLR) begin
      os_act_r <= 1'b0;
      oneshot_out <= 1'b0;
    end else if (os_act_r) begin
      if (match_a) begin
        os_act_r <= 1'b0;
        oneshot_out <= 1'b0;
      end else if (match_b) begin
        oneshot_out <= 1'b1;
      end
    end else if (os_trig) begin
      os_act_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cap_a;
    cap_a_do;
  endsequence
  sequence s_cap_irq_a;
    ##[1:64] (rise_tick && pend_a_r) ##1 irq_capcmp_a_out;
  endsequence

  a_capture_value: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) s_cap_a |=> capcmp_reg_a_r == $past(up_counter_16_r))
    else $error("capture register a value not counter value");
  a_capture_fall: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (cap_a_do || cap_b_do) |-> cnt_clk_r ##1 !cnt_clk_r)
    else $error("capture outside count clock falling edge");
  a_irq_next_rise: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (s_cap_a and (run && DIV_BASE < 8) [*1]) |-> s_cap_irq_a)
    else $error("capture interrupt not at following rising edge");
  a_ext_no_cap: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) ext_cnt |-> !trig_b_r || $past(!ext_cnt))
    else $error("register b captured while input a counts");
  a_cmp_no_cap: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (a_cmp && $past(a_cmp)) |-> !cap_a_do)
    else $error("compare register a captured");
  a_oneshot_mode: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (mode == tmr_cap_pkg::MODE_CMP_CLR) |=> !oneshot_out)
    else $error("one-shot active in compare clear mode");
  a_stop_quiet: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) $past(!run) |-> !edge_a && !edge_b)
    else $error("pin edge seen while stopped");
  a_sample_sel: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) samp_a == (ext_cnt || rise_tick))
    else $error("input a filter on wrong sampling clock");
  a_cfg_locked: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (run && $past(run)) |-> $stable(prescaler_mode_reg_r))
    else $error("edge setting changed while running");
  a_cap_wins: assert property (@(posedge clk_sys_in) disable iff
    (!rst_b_in) (cap_b_do && wr_go) |=>
    capcmp_reg_b_r == $past(up_counter_16_r))
    else $error("bus write beat capture");
endmodule

// *** verif/pulse_source.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module pulse_source (
  // Clock
  input wire logic clk_sys_in,
  // Pins
  output logic pin_a_out,
  output logic pin_b_out
);
  // Both pins rest low
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // Move one pin just after a rising edge
  task automatic set_pin(input logic sel_b, input logic lvl);
    @(posedge clk_sys_in);
    if (sel_b) begin
      pin_b_out <= lvl;
    end else begin
      pin_a_out <= lvl;
    end
  endtask
  // High for hi clocks, then low for lo clocks
  task automatic pulse(input logic sel_b, input int hi, input int lo);
    set_pin(sel_b, 1'b1);
    repeat (hi - 1) @(posedge clk_sys_in);
    set_pin(sel_b, 1'b0);
    repeat (lo - 1) @(posedge clk_sys_in);
  endtask
endmodule

// *** verif/timer_capture_edge_input_test.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////
module timer_capture_edge_input_test;
  logic clk_sys_in, rst_b_in, rd, wr, waitreq, oneshot;
  logic irq_a, irq_b, irq, pin_a, pin_b;
  logic [5:0] adr;
  logic [31:0] wdat, rdat;
  int errors, n_tests;
  // Block and pulse source
  timer_capture_edge_input dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(waitreq),
    .timer_input_a_in(pin_a), .timer_input_b_in(pin_b),
    .oneshot_out(oneshot), .irq_capcmp_a_out(irq_a),
    .irq_capcmp_b_out(irq_b), .irq_out(irq));
  pulse_source src (.clk_sys_in(clk_sys_in), .pin_a_out(pin_a),
    .pin_b_out(pin_b));
  // 40 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////
  // Compare tasks
  task chk_val(input logic [31:0] got, input logic [31:0] exp,
      input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %b", $time, m, got);
    end
  endtask
  // One bus cycle held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_sys_in);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (waitreq !== 1'b0) begin
      errors++;
      $display("[FAIL] %0t bus hang", $time);
      results();
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rreg(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  // Count capture interrupt pulses over a span of clocks
  task automatic cnt_irq(input int cyc, output int na, output int nb,
      output int first);
    na = 0;
    nb = 0;
    first = -1;
    for (int i = 0; i < cyc; i++) begin
      @(negedge clk_sys_in);
      if (irq_a === 1'b1) begin
        if (first < 0) begin
          first = i;
        end
        na++;
      end
      if (irq_b === 1'b1) begin
        nb++;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Pin high from reset: edge at first run, none at a re-run
  task automatic t_startup;
    int na, nb, f;
    wreg(tmr_cap_pkg::OFF_PRM, {26'h0, 4'h5, 2'h0});
    fork
      wreg(tmr_cap_pkg::OFF_CTRL, 32'h1);
      cnt_irq(40, na, nb, f);
    join
    chk_val(32'(na), 32'h1, "first run edge");
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
    fork
      wreg(tmr_cap_pkg::OFF_CTRL, 32'h1);
      cnt_irq(40, na, nb, f);
    join
    chk_val(32'(na + nb), 32'h0, "rerun edge");
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
    src.set_pin(1'b1, 1'b0);
  endtask
  // Each edge selection, capture value and interrupt timing
  task automatic t_edges;
    logic [31:0] c0, c1, cap;
    int na, nb, f;
    int exp[3] = '{1, 1, 2};
    int off[3] = '{8, 0, 0}; // Falling edge comes after the 8-clock high
    for (int e = 0; e < 3; e++) begin
      wreg(tmr_cap_pkg::OFF_PRM, {26'h0, 2'(e), 4'h0});
      wreg(tmr_cap_pkg::OFF_CTRL, 32'h1);
      rreg(tmr_cap_pkg::OFF_COUNT, c0);
      fork
        src.pulse(1'b1, 8, 8);
        cnt_irq(40, na, nb, f);
      join
      rreg(tmr_cap_pkg::OFF_CAPCMP_A, cap);
      rreg(tmr_cap_pkg::OFF_COUNT, c1);
      chk_val(32'(na), 32'(exp[e]), "edge count");
      chk_bit(cap >= c0 && cap <= c1, 1'b1, "capture value");
      chk_bit(f >= 3 + off[e] && f <= 14 + off[e], 1'b1, "irq timing");
      wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
    end
  endtask
  // Short pulse rejected; edge setting frozen while running
  task automatic t_noise;
    logic [31:0] q;
    int na, nb, f;
    wreg(tmr_cap_pkg::OFF_PRM, 32'h13);
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h1);
    wreg(tmr_cap_pkg::OFF_PRM, 32'h0);
    rreg(tmr_cap_pkg::OFF_PRM, q);
    chk_val(q, 32'h13, "edge set while running");
    fork
      src.pulse(1'b1, 3, 2);
      cnt_irq(60, na, nb, f);
    join
    chk_val(32'(na), 32'h0, "noise pulse");
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
  endtask
  // Stopped timer ignores both pins
  task automatic t_stop;
    int na, nb, f;
    wreg(tmr_cap_pkg::OFF_PRM, 32'h28);
    fork
      src.pulse(1'b1, 8, 8);
      src.pulse(1'b0, 8, 8);
      cnt_irq(40, na, nb, f);
    join
    chk_val(32'(na + nb), 32'h0, "stopped pins");
  endtask
  // Compare-mode register keeps its value on a trigger
  task automatic t_cmp;
    logic [31:0] q;
    wreg(tmr_cap_pkg::OFF_CAPCMP_A, 32'h1234);
    wreg(tmr_cap_pkg::OFF_PRM, 32'h10);
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h41);
    src.pulse(1'b1, 8, 24);
    rreg(tmr_cap_pkg::OFF_CAPCMP_A, q);
    chk_val(q, 32'h1234, "compare reg kept");
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
  endtask
  // Input a counts at system clock rate and never captures
  task automatic t_ext;
    logic [31:0] c0, c1, q;
    wreg(tmr_cap_pkg::OFF_CAPCMP_B, 32'h0055);
    wreg(tmr_cap_pkg::OFF_PRM, 32'h07);
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h21);
    rreg(tmr_cap_pkg::OFF_COUNT, c0);
    repeat (3) src.pulse(1'b0, 3, 3);
    rreg(tmr_cap_pkg::OFF_COUNT, c1);
    chk_val(c1 - c0, 32'h3, "fast edges counted");
    rreg(tmr_cap_pkg::OFF_CAPCMP_B, q);
    chk_val(q, 32'h0055, "reg b kept");
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
  endtask
  // One-shot high from match b (4) to match a (8): 4 count clocks of 2
  task automatic t_oneshot;
    int n;
    logic [31:0] ctl[3] = '{32'h19, 32'h1B, 32'h1D};
    int exp[3] = '{8, 0, 8};
    wreg(tmr_cap_pkg::OFF_PRM, 32'h0);
    wreg(tmr_cap_pkg::OFF_CAPCMP_B, 32'h4);
    wreg(tmr_cap_pkg::OFF_CAPCMP_A, 32'h8);
    for (int m = 0; m < 3; m++) begin
      n = 0;
      wreg(tmr_cap_pkg::OFF_CTRL, ctl[m]);
      repeat (40) begin
        @(negedge clk_sys_in);
        if (oneshot === 1'b1) begin
          n++;
        end
      end
      wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
      chk_val(32'(n), 32'(exp[m]), "one-shot width");
    end
  endtask
  // Status, enable, clear and the level interrupt
  task automatic t_irq;
    logic [31:0] q;
    wreg(tmr_cap_pkg::OFF_IRQ_CLR, 32'h7);
    rreg(tmr_cap_pkg::OFF_IRQ_STS, q);
    chk_val(q, 32'h0, "status cleared");
    wreg(tmr_cap_pkg::OFF_IRQ_EN, 32'h1);
    wreg(tmr_cap_pkg::OFF_PRM, 32'h10);
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h1);
    src.pulse(1'b1, 8, 24);
    wreg(tmr_cap_pkg::OFF_CTRL, 32'h0);
    rreg(tmr_cap_pkg::OFF_IRQ_STS, q);
    chk_val(q, 32'h1, "status a set");
    repeat (2) @(negedge clk_sys_in);
    chk_bit(irq, 1'b1, "irq enabled");
    wreg(tmr_cap_pkg::OFF_IRQ_EN, 32'h0);
    repeat (2) @(negedge clk_sys_in);
    chk_bit(irq, 1'b0, "irq masked");
    wreg(tmr_cap_pkg::OFF_IRQ_EN, 32'h1);
    wreg(tmr_cap_pkg::OFF_IRQ_CLR, 32'h1);
    repeat (2) @(negedge clk_sys_in);
    chk_bit(irq, 1'b0, "irq cleared");
    rreg(tmr_cap_pkg::OFF_IRQ_CLR, q);
    chk_val(q, 32'h0, "clear reads zero");
    rreg(6'h3C, q);
    chk_val(q, 32'h0, "unmapped read");
  endtask
  ////////////////////////////////////////////////////////////////
  // Counts and verdict
  task results;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [31:0] q;
    errors = 0;
    n_tests = 0;
    rst_b_in = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h00;
    wdat = 32'h0;
    src.set_pin(1'b1, 1'b1);
    repeat (7) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    rreg(tmr_cap_pkg::OFF_PRM, q);
    chk_val(q, 32'(tmr_cap_pkg::PRM_RESET), "prm reset");
    rreg(tmr_cap_pkg::OFF_CTRL, q);
    chk_val(q, 32'h0, "ctrl reset");
    t_startup();
    t_edges();
    t_noise();
    t_stop();
    t_cmp();
    t_ext();
    t_oneshot();
    t_irq();
    results();
  end
  // Watchdog
  initial begin
    #(25 * 20000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
